// [rxc_pkg.sv]
package rxc_pkg;

  // Lane count and transmit alignment marker values after reset
  localparam int RXC_LANES = 20;
  localparam logic [63:0] RXC_MARKER_RST [RXC_LANES] = '{
    64'hc16821003e97de00, 64'h9d718e00628e7100, 64'h594be800a6b41700,
    64'h4d957b00b26a8400, 64'hf50709000af8f600, 64'hdd14c20022eb3d00,
    64'h9a4a260065b5d900, 64'h7b45660084ba9900, 64'ha02476005fdb8900,
    64'h68c9fb0097360400, 64'hfd6c990002936600, 64'hb9915500466eaa00,
    64'h5cb9b200a3464d00, 64'h1af8bd00e5074200, 64'h83c7ca007c383500,
    64'h3536cd00cac93200, 64'hc4314c003bceb300, 64'hadd6b70052294800,
    64'h5f662a00a099d500, 64'hc0f0e5003f0f1a00
  };

  // Register byte offsets
  localparam logic [8:0] RXC_CTRL_OFS    = 9'h000;
  localparam logic [8:0] RXC_MAXLEN_OFS  = 9'h004;
  localparam logic [8:0] RXC_MINLEN_OFS  = 9'h008;
  localparam logic [8:0] RXC_SPACING_OFS = 9'h00c;
  localparam logic [8:0] RXC_STATUS_OFS  = 9'h010;
  localparam logic [8:0] RXC_MASK_OFS    = 9'h014;
  localparam logic [8:0] RXC_STATE_OFS   = 9'h018;
  localparam logic [8:0] RXC_MARKER_OFS  = 9'h100;

  // Control field positions and values after reset
  localparam int RXC_CTRL_PRE    = 0;
  localparam int RXC_CTRL_SFD    = 1;
  localparam int RXC_CTRL_STRIP  = 2;
  localparam int RXC_CTRL_IGNORE = 3;
  localparam logic [3:0]  RXC_CTRL_RST    = 4'h4;
  localparam logic [14:0] RXC_MAXLEN_RST  = 15'h2580;
  localparam logic [7:0]  RXC_MINLEN_RST  = 8'h40;
  localparam logic [15:0] RXC_SPACING_RST = 16'h3fff;

  // Event bits of status and mask
  localparam int RXC_EV_BAD_FCS  = 0;
  localparam int RXC_EV_OVERSIZE = 1;
  localparam int RXC_EV_UNDER    = 2;
  localparam int RXC_EV_RUNT     = 3;
  localparam int RXC_EV_PREAMBLE = 4;
  localparam int RXC_EV_SFD      = 5;
  localparam int RXC_EV_MARKER   = 6;
  localparam int RXC_EV_W        = 7;

  // Frame constants
  localparam logic [15:0] RXC_RUNT_LEN   = 16'h0040;
  localparam logic [15:0] RXC_STRIP_MIN  = 16'h0008;
  localparam logic [3:0]  RXC_FCS_BYTES  = 4'h4;
  localparam logic [3:0]  RXC_WORD_BYTES = 4'h8;
  localparam logic [55:0] RXC_PREAMBLE   = 56'h55555555555555;
  localparam logic [7:0]  RXC_SFD        = 8'hd5;
  localparam int          RXC_PIPE_DEPTH = 9;

  // Receive packet state, Gray coded
  typedef enum logic [1:0] {
    RXC_IDLE    = 2'b00,
    RXC_BODY    = 2'b01,
    RXC_DISCARD = 2'b11
  } rxc_state_e;

endpackage

// [rxc_lane_markers.sv]
`timescale 1ns/1ps
`default_nettype none
module rxc_lane_markers
  import rxc_pkg::*;
#(
  parameter int LANES = RXC_LANES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Word access, index is lane times two plus upper half
  input  wire logic               wr_en,
  input  wire logic [5:0]         idx,
  input  wire logic [31:0]        wdata,
  output logic      [31:0]        rd_word,
  // Marker patterns, lane n at bits n*64 upward
  output logic      [LANES*64-1:0] pattern
);

  logic [63:0] pat_reg [LANES];

  // One marker register per lane
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pat_reg[g] <= RXC_MARKER_RST[g];
      end else if (wr_en && idx[5:1] == 5'(g)) begin
        if (idx[0]) begin
          pat_reg[g][63:32] <= wdata;
        end else begin
          pat_reg[g][31:0] <= wdata;
        end
      end
    end
    assign pattern[g*64 +: 64] = pat_reg[g];
  end

  // Read half selected by index, zero past the last lane
  always_comb begin
    rd_word = 32'h0;
    if (int'(idx[5:1]) < LANES) begin
      rd_word = idx[0] ? pat_reg[idx[5:1]][63:32] : pat_reg[idx[5:1]][31:0];
    end
  end

endmodule // rxc_lane_markers
`default_nettype wire

// [rxc_marker_spacing.sv]
`timescale 1ns/1ps
`default_nettype none
module rxc_marker_spacing
  import rxc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Lane words
  input  wire logic        word_stb,
  input  wire logic        marker,
  input  wire logic [15:0] spacing_m1,
  // Spacing state
  output var  logic        lock,
  output var  logic        err
);

  logic [16:0] cnt_reg;
  logic        due;

  // Marker expected after spacing plus one data words
  assign due = cnt_reg == {1'b0, spacing_m1} + 17'h1;

  // Word count since the last marker, lock and error pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 17'h0;
      lock    <= 1'b0;
      err     <= 1'b0;
    end else begin
      err <= 1'b0;
      if (word_stb) begin
        if (marker) begin
          err     <= lock && !due;   // Early marker
          lock    <= 1'b1;
          cnt_reg <= 17'h0;
        end else if (lock && due) begin
          err     <= 1'b1;           // Missing marker
          lock    <= 1'b0;
          cnt_reg <= 17'h0;
        end else begin
          cnt_reg <= cnt_reg + 17'h1;
        end
      end
    end
  end

endmodule // rxc_marker_spacing
`default_nettype wire

// [rxc_frame_check.sv]
// Operation
// - Lanes 6-19 emit configured 64-bit markers
// - Preamble checked only when enabled
// - Start delimiter checked only when enabled
// - Strip four-byte FCS when enabled
// - Keep FCS for packets of eight bytes
// - Ignore setting hides FCS error flag
// - Bad FCS raises error on last transfer
// - Ignored bad FCS counted good, still pulsed
// - Oversize truncated to maximum, error at end
// - Packets under 64 bytes are dropped
// - Below minimum length raises end error
// - Receive markers every spacing plus one
// - Lanes 0-5 emit configured markers too
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rxc_frame_check
  import rxc_pkg::*;
#(
  parameter int DEPTH = RXC_PIPE_DEPTH
) (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RST_B,
  // Register port
  input  wire logic [8:0]              ADDR,
  input  wire logic [31:0]             WR_DATA,
  input  wire logic                    WR_STB,
  input  wire logic                    RD_STB,
  output var  logic [31:0]             RD_DATA,
  // Receive frame words from the lane side
  input  wire logic                    IN_VALID,
  input  wire logic                    IN_SOP,
  input  wire logic                    IN_EOP,
  input  wire logic [2:0]              IN_MTY,
  input  wire logic [63:0]             IN_DATA,
  input  wire logic [63:0]             IN_PREAMBLE,
  input  wire logic                    IN_FCS_BAD,
  // Receive lane words for marker spacing
  input  wire logic                    PCS_WORD_STB,
  input  wire logic                    PCS_MARKER,
  // Segmented local packet bus
  output logic                         RX_SEGMENT_VALID,
  output logic                         RX_SOP,
  output logic                         RX_EOP,
  output logic                         RX_ERR,
  output logic      [2:0]              RX_MTY,
  output logic      [63:0]             RX_DATA,
  // Packet statistics and lane state
  output var  logic                    STAT_BAD_FCS,
  output var  logic                    STAT_GOOD_PKT,
  output var  logic                    STAT_BAD_PKT,
  output logic                         RX_MARKER_LOCK,
  // Transmit alignment markers
  output logic      [RXC_LANES*64-1:0] TX_LANE_ALIGN_PATTERN,
  // Interrupt
  output var  logic                    IRQ
);

  // Configuration, status and mask registers
  logic [3:0]          ctrl_reg;
  logic [14:0]         maxlen_reg;
  logic [7:0]          minlen_reg;
  logic [15:0]         spacing_reg;
  logic [RXC_EV_W-1:0] status_reg;
  logic [RXC_EV_W-1:0] mask_reg;
  logic [RXC_EV_W-1:0] events;

  // Per-packet copy of the settings
  logic [3:0]          lat_ctrl_reg;
  logic [14:0]         lat_max_reg;
  logic [7:0]          lat_min_reg;

  // Packet tracking
  rxc_state_e          state_reg;
  logic [15:0]         cnt_reg;
  logic                perr_reg;

  // Delay pipe, entry 0 newest
  logic [DEPTH-1:0]    pv_reg, ps_reg, pe_reg, pr_reg;
  logic [DEPTH-1:0]    pv_next, ps_next, pe_next, pr_next;
  logic [2:0]          pm_reg [DEPTH];
  logic [2:0]          pm_next [DEPTH];
  logic [63:0]         pd_reg [DEPTH];
  logic [63:0]         pd_next [DEPTH];

  // Word decode
  logic                take, over, eop_now, err_now, runt, under;
  logic                fcs_err, strip, pre_bad, sfd_bad, perr;
  logic [3:0]          vb, keep;
  logic [15:0]         base_cnt, len_sum;

  // Register port decode
  logic                mk_hit, mk_wr, mk_err;
  logic [5:0]          mk_idx;
  logic [31:0]         mk_rd;
  logic [8:0]          mk_ofs;

  assign mk_ofs = ADDR - RXC_MARKER_OFS;
  assign mk_hit = ADDR >= RXC_MARKER_OFS &&
                  ADDR < RXC_MARKER_OFS + 9'(RXC_LANES * 8);
  assign mk_idx = mk_ofs[7:2];
  assign mk_wr  = WR_STB && mk_hit;

  rxc_lane_markers #(
    .LANES   (RXC_LANES)
  ) u_markers (
    .clk     (CLK),
    .rst_b   (RST_B),
    .wr_en   (mk_wr),
    .idx     (mk_idx),
    .wdata   (WR_DATA),
    .rd_word (mk_rd),
    .pattern (TX_LANE_ALIGN_PATTERN)
  );

  rxc_marker_spacing u_spacing (
    .clk        (CLK),
    .rst_b      (RST_B),
    .word_stb   (PCS_WORD_STB),
    .marker     (PCS_MARKER),
    .spacing_m1 (spacing_reg),
    .lock       (RX_MARKER_LOCK),
    .err        (mk_err)
  );

  // Configuration register writes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg    <= RXC_CTRL_RST;
      maxlen_reg  <= RXC_MAXLEN_RST;
      minlen_reg  <= RXC_MINLEN_RST;
      spacing_reg <= RXC_SPACING_RST;
      mask_reg    <= '0;
    end else if (WR_STB) begin
      case (ADDR)
        RXC_CTRL_OFS:    ctrl_reg    <= WR_DATA[3:0];
        RXC_MAXLEN_OFS:  maxlen_reg  <= WR_DATA[14:0];
        RXC_MINLEN_OFS:  minlen_reg  <= WR_DATA[7:0];
        RXC_SPACING_OFS: spacing_reg <= WR_DATA[15:0];
        RXC_MASK_OFS:    mask_reg    <= WR_DATA[RXC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      lat_ctrl_reg <= RXC_CTRL_RST;
      lat_max_reg  <= RXC_MAXLEN_RST;
      lat_min_reg  <= RXC_MINLEN_RST;
    end else if (!(IN_VALID && IN_SOP) && state_reg != RXC_BODY) begin
      lat_ctrl_reg <= ctrl_reg;
      lat_max_reg  <= maxlen_reg;
      lat_min_reg  <= minlen_reg;
    end
  end

  // Length and check decode of the incoming word
  always_comb begin
    take     = IN_VALID && (IN_SOP || state_reg == RXC_BODY);
    vb       = IN_EOP ? RXC_WORD_BYTES - {1'b0, IN_MTY} : RXC_WORD_BYTES;
    base_cnt = IN_SOP ? 16'h0 : cnt_reg;
    len_sum  = base_cnt + {12'h0, vb};
    keep     = 4'({1'b0, lat_max_reg} - base_cnt);
    over     = take && (len_sum > {1'b0, lat_max_reg} ||
               (!IN_EOP && len_sum == {1'b0, lat_max_reg}));
    pre_bad  = take && IN_SOP && lat_ctrl_reg[RXC_CTRL_PRE] &&
               IN_PREAMBLE[55:0] != RXC_PREAMBLE;
    sfd_bad  = take && IN_SOP && lat_ctrl_reg[RXC_CTRL_SFD] &&
               IN_PREAMBLE[63:56] != RXC_SFD;
    perr     = (IN_SOP ? 1'b0 : perr_reg) | pre_bad | sfd_bad;
    eop_now  = take && (IN_EOP || over);
    runt     = take && IN_EOP && !over && len_sum < RXC_RUNT_LEN;
    under    = take && IN_EOP && !over && len_sum < {8'h0, lat_min_reg};
    fcs_err  = take && IN_EOP && !over && IN_FCS_BAD &&
               !lat_ctrl_reg[RXC_CTRL_IGNORE];
    err_now  = eop_now && (over || under || fcs_err || perr);
    // strip enable, not for short packets
    strip    = take && IN_EOP && !over && lat_ctrl_reg[RXC_CTRL_STRIP] &&
               len_sum > RXC_STRIP_MIN;
  end

  // Pipe next state: shift, insert, strip and drop
  always_comb begin
    logic go;
    go = runt;
    pv_next[0] = take;
    ps_next[0] = take && IN_SOP;
    pe_next[0] = eop_now;
    pr_next[0] = err_now;
    pm_next[0] = over ? 3'(RXC_WORD_BYTES - keep) : IN_MTY;
    pd_next[0] = IN_DATA;
    for (int i = 1; i < DEPTH; i++) begin
      pv_next[i] = pv_reg[i-1];
      ps_next[i] = ps_reg[i-1];
      pe_next[i] = pe_reg[i-1];
      pr_next[i] = pr_reg[i-1];
      pm_next[i] = pm_reg[i-1];
      pd_next[i] = pd_reg[i-1];
    end
    if (strip) begin
      if (vb > RXC_FCS_BYTES) begin
        pm_next[0] = IN_MTY + 3'(RXC_FCS_BYTES);
      end else begin
        pv_next[0] = 1'b0;
        pe_next[1] = 1'b1;
        pr_next[1] = err_now;
        pm_next[1] = 3'(RXC_FCS_BYTES - vb);
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (go) begin
        pv_next[i] = 1'b0;
        if (ps_next[i]) begin
          go = 1'b0;
        end
      end
    end
  end

  // Pipe registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pv_reg <= '0;
      ps_reg <= '0;
      pe_reg <= '0;
      pr_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        pm_reg[i] <= 3'h0;
        pd_reg[i] <= 64'h0;
      end
    end else begin
      pv_reg <= pv_next;
      ps_reg <= ps_next;
      pe_reg <= pe_next;
      pr_reg <= pr_next;
      for (int i = 0; i < DEPTH; i++) begin
        pm_reg[i] <= pm_next[i];
        pd_reg[i] <= pd_next[i];
      end
    end
  end

  // Packet bus straight from the oldest pipe entry
  assign RX_SEGMENT_VALID = pv_reg[DEPTH-1];
  assign RX_SOP           = ps_reg[DEPTH-1] && pv_reg[DEPTH-1];
  assign RX_EOP           = pe_reg[DEPTH-1] && pv_reg[DEPTH-1];
  assign RX_ERR           = pr_reg[DEPTH-1] && pv_reg[DEPTH-1];
  assign RX_MTY           = pm_reg[DEPTH-1];
  assign RX_DATA          = pd_reg[DEPTH-1];

  // Packet state, byte count and sticky header error
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= RXC_IDLE;
      cnt_reg   <= 16'h0;
      perr_reg  <= 1'b0;
    end else begin
      if (take) begin
        cnt_reg  <= len_sum;
        perr_reg <= perr;
        if (!eop_now) begin
          state_reg <= RXC_BODY;
        end else if (over && !IN_EOP) begin
          state_reg <= RXC_DISCARD;   // Drop the rest
        end else begin
          state_reg <= RXC_IDLE;
        end
      end else if (state_reg == RXC_DISCARD && IN_VALID && IN_EOP) begin
        state_reg <= RXC_IDLE;
      end
    end
  end

  // Statistics pulses at the end of each received packet
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      STAT_BAD_FCS  <= 1'b0;
      STAT_GOOD_PKT <= 1'b0;
      STAT_BAD_PKT  <= 1'b0;
    end else begin
      STAT_BAD_FCS  <= take && IN_EOP && !over && IN_FCS_BAD;
      STAT_GOOD_PKT <= eop_now && !err_now && !runt;
      STAT_BAD_PKT  <= eop_now && (err_now || runt);
    end
  end

  // Event sources
  always_comb begin
    events                  = '0;
    events[RXC_EV_BAD_FCS]  = take && IN_EOP && !over && IN_FCS_BAD;
    events[RXC_EV_OVERSIZE] = over;
    events[RXC_EV_UNDER]    = under && !runt;
    events[RXC_EV_RUNT]     = runt;
    events[RXC_EV_PREAMBLE] = pre_bad;
    events[RXC_EV_SFD]      = sfd_bad;
    events[RXC_EV_MARKER]   = mk_err;
  end

  // Sticky status, write one to clear, new event wins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_reg <= '0;
    end else if (WR_STB && ADDR == RXC_STATUS_OFS) begin
      status_reg <= (status_reg & ~WR_DATA[RXC_EV_W-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_reg & mask_reg);
    end
  end

  // Read data, one cycle after the strobe only
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= 32'h0;
    end else if (!RD_STB) begin
      RD_DATA <= 32'h0;
    end else if (mk_hit) begin
      RD_DATA <= mk_rd;
    end else begin
      case (ADDR)
        RXC_CTRL_OFS:    RD_DATA <= {28'h0, ctrl_reg};
        RXC_MAXLEN_OFS:  RD_DATA <= {17'h0, maxlen_reg};
        RXC_MINLEN_OFS:  RD_DATA <= {24'h0, minlen_reg};
        RXC_SPACING_OFS: RD_DATA <= {16'h0, spacing_reg};
        RXC_STATUS_OFS:  RD_DATA <= {25'h0, status_reg};
        RXC_MASK_OFS:    RD_DATA <= {25'h0, mask_reg};
        RXC_STATE_OFS:   RD_DATA <= {29'h0, RX_MARKER_LOCK, state_reg};
        default:         RD_DATA <= 32'h0;
      endcase
    end
  end

endmodule // rxc_frame_check
`default_nettype wire

// [rxc_frame_check_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module rxc_frame_check_sva
  import rxc_pkg::*;
#(
  parameter int DEPTH = RXC_PIPE_DEPTH
) (
  // Clock, reset and setting writes
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [8:0]  ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic        WR_STB,
  // Frame words in
  input wire logic        IN_VALID,
  input wire logic        IN_SOP,
  input wire logic        IN_EOP,
  input wire logic [2:0]  IN_MTY,
  input wire logic        IN_FCS_BAD,
  // Packet bus and statistics
  input wire logic        RX_SEGMENT_VALID,
  input wire logic        RX_EOP,
  input wire logic        RX_ERR,
  input wire logic [2:0]  RX_MTY,
  input wire logic        STAT_BAD_FCS,
  input wire logic        STAT_GOOD_PKT,
  input wire logic        STAT_BAD_PKT
);
  localparam int DM1 = DEPTH - 1;
  logic [3:0]  ctl_reg;
  logic [15:0] max_reg;
  logic [15:0] min_reg;
  logic [15:0] len_reg;
  logic [15:0] prev;
  logic [15:0] len;
  logic        eop;
  logic        fit;
  logic        ign_ok;

  // Shadow of the written settings
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_reg <= RXC_CTRL_RST;
      max_reg <= {1'b0, RXC_MAXLEN_RST};
      min_reg <= {8'h00, RXC_MINLEN_RST};
    end else if (WR_STB) begin
      if (ADDR == RXC_CTRL_OFS) ctl_reg <= WR_DATA[3:0];
      if (ADDR == RXC_MAXLEN_OFS) max_reg <= {1'b0, WR_DATA[14:0]};
      if (ADDR == RXC_MINLEN_OFS) min_reg <= {8'h00, WR_DATA[7:0]};
    end
  end

  // Running byte count of the incoming frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) len_reg <= 16'h0000;
    else if (IN_VALID) len_reg <= len;
  end
  assign prev = IN_SOP ? 16'h0000 : len_reg;
  assign len = prev + 16'h0008 - (IN_EOP ? {13'h0000, IN_MTY} : 16'h0000);
  assign eop = IN_VALID && IN_EOP;
  assign fit = len >= RXC_RUNT_LEN && len <= max_reg;
  assign ign_ok = eop && fit && IN_FCS_BAD && ctl_reg[3]
                  && ctl_reg[1:0] == 2'b00 && len >= min_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  err_at_end_a:
    assert property (RX_ERR |-> RX_EOP && RX_SEGMENT_VALID)
    else $error("error away from packet end");
  fcs_error_a:
    assert property (eop && fit && IN_FCS_BAD && !ctl_reg[3]
                     |-> ##[DM1:DEPTH] RX_EOP && RX_ERR)
    else $error("bad checksum not flagged");
  fcs_hidden_a:
    assert property (ign_ok |-> ##[DM1:DEPTH] RX_EOP && !RX_ERR)
    else $error("ignored checksum still flagged");
  ign_counted_a:
    assert property (ign_ok
                     |=> STAT_GOOD_PKT && !STAT_BAD_PKT && STAT_BAD_FCS)
    else $error("ignored checksum miscounted");
  runt_drop_a:
    assert property (eop && len < RXC_RUNT_LEN
                     |=> STAT_BAD_PKT ##DM1 !RX_EOP)
    else $error("runt not dropped");
  trunc_end_a:
    assert property (IN_VALID && prev < max_reg && len >= max_reg
                     && !(IN_EOP && len == max_reg)
                     |-> ##DEPTH RX_EOP && RX_ERR)
    else $error("oversize not cut");
  short_err_a:
    assert property (eop && fit && len < min_reg
                     |-> ##[DM1:DEPTH] RX_EOP && RX_ERR)
    else $error("undersize not flagged");
  strip_mty_a:
    assert property (eop && fit && ctl_reg[2] && IN_MTY < 3'h4
                     |-> ##DEPTH RX_EOP
                     && RX_MTY == $past(IN_MTY, DEPTH) + 3'h4)
    else $error("checksum not removed");
  keep_mty_a:
    assert property (eop && fit && !ctl_reg[2]
                     |-> ##DEPTH RX_EOP && RX_MTY == $past(IN_MTY, DEPTH))
    else $error("checksum removed while kept");
endmodule // rxc_frame_check_sva

bind rxc_frame_check rxc_frame_check_sva #(.DEPTH(DEPTH)) u_chk (
  .CLK, .RST_B, .ADDR, .WR_DATA, .WR_STB, .IN_VALID, .IN_SOP, .IN_EOP,
  .IN_MTY, .IN_FCS_BAD, .RX_SEGMENT_VALID, .RX_EOP, .RX_ERR, .RX_MTY,
  .STAT_BAD_FCS, .STAT_GOOD_PKT, .STAT_BAD_PKT
);
`default_nettype wire

// [rxc_user_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module rxc_user_sink (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Packet bus from the receiver
  input  wire logic        RX_SEGMENT_VALID,
  input  wire logic        RX_SOP,
  input  wire logic        RX_EOP,
  input  wire logic        RX_ERR,
  input  wire logic [2:0]  RX_MTY,
  // Last packet seen
  output logic      [7:0]  pkt_cnt,
  output logic      [15:0] pkt_len,
  output logic             pkt_err
);
  logic [15:0] acc_reg;
  logic [15:0] sum;

  // Bytes up to and including this word
  assign sum = (RX_SOP ? 16'h0000 : acc_reg) + 16'h0008
               - (RX_EOP ? {13'h0000, RX_MTY} : 16'h0000);

  // Takes every word, no back-pressure
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_reg <= 16'h0000;
      pkt_cnt <= 8'h00;
      pkt_len <= 16'h0000;
      pkt_err <= 1'b0;
    end else if (RX_SEGMENT_VALID) begin
      acc_reg <= sum;
      if (RX_EOP) begin
        pkt_cnt <= pkt_cnt + 8'h01;
        pkt_len <= sum;
        pkt_err <= RX_ERR;
      end
    end
  end
endmodule // rxc_user_sink
`default_nettype wire

// [rxc_frame_check_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rxc_frame_check_tb
  import rxc_pkg::*;
;
  localparam logic [63:0] GP = {RXC_SFD, RXC_PREAMBLE};
  localparam logic [63:0] SB = GP ^ 64'h0100000000000000;
  // Stimulus
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [8:0]  ADDR = 9'h000;
  logic [31:0] WR_DATA = 32'h0;
  logic        WR_STB = 1'b0;
  logic        RD_STB = 1'b0;
  logic        IN_VALID = 1'b0;
  logic        IN_SOP = 1'b0;
  logic        IN_EOP = 1'b0;
  logic [2:0]  IN_MTY = 3'h0;
  logic [63:0] IN_DATA = 64'h0;
  logic [63:0] IN_PREAMBLE = 64'h0;
  logic        IN_FCS_BAD = 1'b0;
  logic        PCS_WORD_STB = 1'b0;
  logic        PCS_MARKER = 1'b0;
  // Design outputs and tallies
  logic [31:0] RD_DATA;
  logic        RX_SEGMENT_VALID, RX_SOP, RX_EOP, RX_ERR;
  logic [2:0]  RX_MTY;
  logic [63:0] RX_DATA, eop_d;
  logic        STAT_BAD_FCS, STAT_GOOD_PKT, STAT_BAD_PKT;
  logic        RX_MARKER_LOCK, IRQ;
  logic [RXC_LANES*64-1:0] TX_LANE_ALIGN_PATTERN;
  logic [7:0]  pkt_cnt;
  logic [15:0] pkt_len;
  logic        pkt_err;
  int          errors = 0;
  int          tests_run = 0;
  int          n_good = 0;
  int          n_bad = 0;
  int          n_fcs = 0;

  always #2.5 CLK = ~CLK;

  rxc_frame_check dut (
    .CLK, .RST_B, .ADDR, .WR_DATA, .WR_STB, .RD_STB, .RD_DATA,
    .IN_VALID, .IN_SOP, .IN_EOP, .IN_MTY, .IN_DATA, .IN_PREAMBLE,
    .IN_FCS_BAD, .PCS_WORD_STB, .PCS_MARKER, .RX_SEGMENT_VALID, .RX_SOP,
    .RX_EOP, .RX_ERR, .RX_MTY, .RX_DATA, .STAT_BAD_FCS, .STAT_GOOD_PKT,
    .STAT_BAD_PKT, .RX_MARKER_LOCK, .TX_LANE_ALIGN_PATTERN, .IRQ
  );
  rxc_user_sink sink (
    .CLK, .RST_B, .RX_SEGMENT_VALID, .RX_SOP, .RX_EOP, .RX_ERR, .RX_MTY,
    .pkt_cnt, .pkt_len, .pkt_err
  );

  // Statistic pulses seen
  always @(posedge CLK) begin
    if (RX_EOP === 1'b1) eop_d = RX_DATA;
    if (STAT_GOOD_PKT === 1'b1) n_good++;
    if (STAT_BAD_PKT === 1'b1) n_bad++;
    if (STAT_BAD_FCS === 1'b1) n_fcs++;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask

  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1 chk(64'(RD_DATA), 64'(e));
  endtask

  // Gapless frame of n bytes, bounded wait for the sink
  task automatic send(input int n, input logic bad, input logic [63:0] p,
                      input logic out);
    int w;
    int k;
    logic [7:0] c0;
    w = (n + 7) / 8;
    c0 = pkt_cnt;
    for (int i = 0; i < w; i++) begin
      @(posedge CLK);
      IN_VALID <= 1'b1;
      IN_SOP <= (i == 0);
      IN_EOP <= (i == w - 1);
      IN_MTY <= (i == w - 1) ? 3'(w * 8 - n) : 3'h0;
      IN_DATA <= {2{32'(i)}};
      IN_PREAMBLE <= p;
      IN_FCS_BAD <= bad;
    end
    @(posedge CLK);
    IN_VALID <= 1'b0;
    IN_SOP <= 1'b0;
    IN_EOP <= 1'b0;
    for (k = 0; k < 14 && pkt_cnt == c0; k++) @(posedge CLK);
    if (out && pkt_cnt == c0) begin
      errors++;
      $display("FAIL %0t: no packet", $time);
      tally_and_finish();
    end
    chk(64'(pkt_cnt), 64'(c0) + 64'(out));
  endtask

  task automatic words(input int n, input logic m);
    for (int i = 0; i <= n; i++) begin
      @(posedge CLK);
      PCS_WORD_STB <= (i < n) || m;
      PCS_MARKER <= (i == n) && m;
    end
    @(posedge CLK);
    PCS_WORD_STB <= 1'b0;
    PCS_MARKER <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask

  task automatic pre_case(input logic [31:0] c, input logic [63:0] p,
                          input logic e);
    wr(RXC_CTRL_OFS, c);
    send(72, 1'b0, p, 1'b1);
    chk(64'(pkt_err), 64'(e));
  endtask

  task automatic t_regs();
    rchk(RXC_CTRL_OFS, 32'h4);
    rchk(RXC_MAXLEN_OFS, 32'h2580);
    rchk(RXC_MINLEN_OFS, 32'h40);
    rchk(RXC_SPACING_OFS, 32'h3fff);
    rchk(RXC_MARKER_OFS + 9'h034, 32'h9a4a2600);
    chk(TX_LANE_ALIGN_PATTERN[6*64 +: 64], 64'h9a4a260065b5d900);
    chk(TX_LANE_ALIGN_PATTERN[19*64 +: 64], 64'hc0f0e5003f0f1a00);
    chk(TX_LANE_ALIGN_PATTERN[0 +: 64], 64'hc16821003e97de00);
    chk(TX_LANE_ALIGN_PATTERN[5*64 +: 64], 64'hdd14c20022eb3d00);
    wr(RXC_MARKER_OFS + 9'h098, 32'h12345678);
    wr(RXC_MARKER_OFS + 9'h09c, 32'h9abcdef0);
    wr(9'h1a0, 32'hffffffff);
    rchk(9'h1a0, 32'h0);
    chk(TX_LANE_ALIGN_PATTERN[19*64 +: 64], 64'h9abcdef012345678);
  endtask

  task automatic t_marker();
    wr(RXC_SPACING_OFS, 32'h3);
    words(0, 1'b1);
    chk(64'(RX_MARKER_LOCK), 64'h1);
    words(4, 1'b1);
    chk(64'(RX_MARKER_LOCK), 64'h1);
    rchk(RXC_STATUS_OFS, 32'h0);
    words(5, 1'b0);
    chk(64'(RX_MARKER_LOCK), 64'h0);
    rchk(RXC_STATUS_OFS, 32'h40);
    wr(RXC_STATUS_OFS, 32'h40);
  endtask

  task automatic t_fcs();
    int g;
    int f;
    send(72, 1'b0, GP, 1'b1);
    chk(64'(pkt_len), 64'd68);
    chk(eop_d, {2{32'h8}});
    send(68, 1'b0, GP, 1'b1);
    chk(64'(pkt_len), 64'd64);
    send(72, 1'b1, GP, 1'b1);
    chk(64'(pkt_err), 64'h1);
    rchk(RXC_STATUS_OFS, 32'h1);
    chk(64'(IRQ), 64'h0);
    wr(RXC_MASK_OFS, 32'h1);
    repeat (2) @(posedge CLK);
    chk(64'(IRQ), 64'h1);
    wr(RXC_STATUS_OFS, 32'h1);
    repeat (2) @(posedge CLK);
    chk(64'(IRQ), 64'h0);
    wr(RXC_CTRL_OFS, 32'hc);
    g = n_good;
    f = n_fcs;
    send(72, 1'b1, GP, 1'b1);
    chk(64'(pkt_err), 64'h0);
    chk(64'(n_good - g), 64'h1);
    chk(64'(n_fcs - f), 64'h1);
    wr(RXC_CTRL_OFS, 32'h8);
    send(69, 1'b0, GP, 1'b1);
    chk(64'(pkt_len), 64'd69);
    wr(RXC_STATUS_OFS, 32'h7f);
  endtask

  task automatic t_len();
    int b;
    wr(RXC_CTRL_OFS, 32'h4);
    b = n_bad;
    send(60, 1'b0, GP, 1'b0);
    chk(64'(n_bad - b), 64'h1);
    send(64, 1'b0, GP, 1'b1);
    chk(64'(pkt_len), 64'd60);
    wr(RXC_MINLEN_OFS, 32'h50);
    send(72, 1'b0, GP, 1'b1);
    chk(64'(pkt_err), 64'h1);
    wr(RXC_MINLEN_OFS, 32'h40);
    wr(RXC_MAXLEN_OFS, 32'h50);
    send(96, 1'b0, GP, 1'b1);
    chk(64'(pkt_len), 64'd80);
    chk(64'(pkt_err), 64'h1);
    wr(RXC_MAXLEN_OFS, 32'h2580);
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs();
    t_marker();
    t_fcs();
    t_len();
    pre_case(32'h4, GP ^ 64'h1, 1'b0);
    pre_case(32'h5, GP ^ 64'h1, 1'b1);
    pre_case(32'h5, GP, 1'b0);
    pre_case(32'h4, SB, 1'b0);
    pre_case(32'h6, SB, 1'b1);
    tally_and_finish();
  end
endmodule // rxc_frame_check_tb
`default_nettype wire
